// ---- src/ext_bus_port_pins.sv ----
// external memory bus and multi-function port pin logic
//
// Operation
// - Port 2 drives the high address byte on fetches and wide data moves.
// - Port 2 drives ones strongly while it carries an address.
// - Narrow indirect data moves put the port 2 latch on port 2.
// - Port 2 and 3 bits holding one are weakly pulled high as inputs.
// - Port 3 bit 0 is serial receive, bit 1 serial transmit.
// - Port 3 bit 6 is the data write strobe, bit 7 the read strobe.
// - Port 3 bits 2..5 feed interrupts 0, 1 and timer 0, 1 counts.
// - Port 1 bit 1 feeds the timer 2 auxiliary control.
// - Reset pin high for two machine cycles resets; the board holds it.
// - Address latch pulse marks each external access; board latches low address.
// - Address latch pulse runs freely at one sixth of oscillator rate.
// - One address latch pulse is dropped in each data access cycle.
// - Program fetch strobe fires twice per machine cycle when fetching.
// - Two program fetch strobes are dropped in each data access.
// - Port 0 carries multiplexed low address and data bytes.
// - Auxiliary bit 0 leaves address latch active only for data moves.
`include "ext_bus_defines.svh"
`default_nettype none
module ext_bus_port_pins
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic code_source_select_n,
  input wire logic fetch_en,
  input wire logic [15:0] code_addr,
  input wire logic data_req_valid,
  input wire data_req_t data_req,
  input wire logic ale_off,
  input wire logic [7:0] high_addr_port_latch,
  input wire logic [7:0] p3_latch,
  input wire logic txd_bit,
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p3_in,
  output logic [7:0] code_byte,
  output logic code_valid,
  output logic data_ack,
  output logic [7:0] data_rdata,
  output pin_drive_t p0_pins,
  output pin_drive_t port2_pins,
  output pin_drive_t p3_pins,
  output logic port2_strong,
  output logic addr_latch_en,
  output logic program_fetch_strobe_n,
  output alt_in_t alt_in,
  output logic core_reset
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // position inside the current half machine cycle
  function automatic logic [3:0] slot_off(input logic [3:0] ph);
    slot_off = (ph >= `SLOT_LEN) ? ph - `SLOT_LEN : ph;
  endfunction

  // true when a phase lies in a closed range
  function automatic logic in_span(input logic [3:0] v, input logic [3:0] lo,
                                   input logic [3:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  logic [3:0] phase;

  machine_cycle_timer machine_cycle_timer_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .phase(phase)
  );

  reset_hold_filter reset_hold_filter_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reset_pin(reset_pin),
    .core_reset(core_reset)
  );

  // ----------------------------------------
  // cycle selection
  // ----------------------------------------
  bus_cyc_t cyc_q;
  bus_cyc_t cyc_d;
  data_req_t req_q;
  data_req_t req_d;
  logic [15:0] fetch_addr_q;
  logic [3:0] off;
  logic mc_end;
  logic take;
  logic ext_fetch;
  logic is_data;
  logic is_code;
  logic slot_a;
  logic [15:0] slot_addr;

  assign off = slot_off(phase);
  assign mc_end = (phase == `MC_LAST);
  assign slot_a = (phase < `SLOT_LEN);
  assign is_data = (cyc_q == DATA_CYC);
  assign is_code = (cyc_q == CODE_CYC);
  // code comes from outside only while the select input is low
  assign ext_fetch = fetch_en && !code_source_select_n;
  // a data move is taken at the end of a cycle that is not itself a data cycle
  assign take = mc_end && data_req_valid && !is_data;
  assign req_d = take ? data_req : req_q;
  // the fetch address is sampled at the start of each slot
  assign slot_addr = (off == 4'h0) ? code_addr : fetch_addr_q;

  // next cycle kind
  always_comb begin
    cyc_d = cyc_q;
    if (mc_end) begin
      if (take) begin
        cyc_d = DATA_CYC;
      end else if (ext_fetch) begin
        cyc_d = CODE_CYC;
      end else begin
        cyc_d = IDLE_CYC;
      end
    end
  end

  // ----------------------------------------
  // strobe generation
  // ----------------------------------------
  logic ale_slot;
  logic ale_d;
  logic fetch_n_d;
  logic strobe_win;
  logic rd_n_d;
  logic wr_n_d;

  assign ale_slot = in_span(off, `ALE_FIRST, `ALE_LAST);
  // free running pulse, dropped in the second half of a data cycle
  assign ale_d = ale_slot && (is_data ? slot_a : !ale_off);
  // two fetch strobes per code cycle, none in a data cycle
  assign fetch_n_d = !(is_code && in_span(off, `FETCH_FIRST, `FETCH_LAST));
  assign strobe_win = is_data && in_span(phase, `STROBE_FIRST, `STROBE_LAST);
  assign rd_n_d = !(strobe_win && !req_q.write);
  assign wr_n_d = !(strobe_win && req_q.write);

  // ----------------------------------------
  // port 0 multiplexed bus
  // ----------------------------------------
  pin_drive_t p0_d;
  logic addr_time;
  logic [15:0] bus_addr;

  assign addr_time = (off <= `ADDR_LAST) && (is_code || (is_data && slot_a));
  assign bus_addr = is_data ? req_q.addr : slot_addr;
  // low address first, then write data, otherwise released for input
  assign p0_d.level = addr_time ? bus_addr[7:0] : req_q.wdata;
  assign p0_d.oe = (addr_time || (is_data && req_q.write && phase >= `STROBE_FIRST))
                   ? 8'hff : 8'h00;
  assign p0_d.weak_pu = 8'h00;

  // ----------------------------------------
  // port 2 address or latch
  // ----------------------------------------
  pin_drive_t port2_d;
  logic port2_addr;

  // high address on fetches and wide moves, latch on narrow moves
  assign port2_addr = is_code || (is_data && req_q.wide);
  assign port2_d.level = port2_addr ? bus_addr[15:8] : high_addr_port_latch;
  // address ones are driven hard, latch ones only pulled weakly
  assign port2_d.oe = port2_addr ? 8'hff : ~high_addr_port_latch;
  assign port2_d.weak_pu = port2_addr ? 8'h00 : high_addr_port_latch;

  // ----------------------------------------
  // port 3 alternate outputs
  // ----------------------------------------
  pin_drive_t p3_d;
  logic [7:0] p3_alt;

  // transmit and strobes pull low through the latch value
  assign p3_alt = {rd_n_d, wr_n_d, 4'hf, txd_bit, 1'b1};
  assign p3_d.level = p3_latch & p3_alt;
  assign p3_d.oe = ~p3_d.level;
  assign p3_d.weak_pu = p3_d.level;

  // ----------------------------------------
  // alternate inputs
  // ----------------------------------------
  alt_in_t alt_d;

  assign alt_d.rx = p3_in[`P3_RX];
  assign alt_d.irq0 = p3_in[`P3_IRQ0];
  assign alt_d.irq1 = p3_in[`P3_IRQ1];
  assign alt_d.timer_zero_count_in = p3_in[`P3_CNT0];
  assign alt_d.timer_one_count_in = p3_in[`P3_CNT1];
  assign alt_d.t2_aux = p1_in[`P1_T2AUX];

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  logic fetch_n_q;
  logic rd_n_q;
  logic code_cap;
  logic data_cap;

  // sample port 0 as each read strobe ends
  assign code_cap = !fetch_n_q && fetch_n_d;
  assign data_cap = !rd_n_q && rd_n_d;

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q <= IDLE_CYC;
      req_q <= '0;
      fetch_addr_q <= 16'h0000;
    end else begin
      cyc_q <= cyc_d;
      req_q <= req_d;
      fetch_addr_q <= slot_addr;
    end
  end

  // ----------------------------------------
  // pin registers
  // ----------------------------------------
  logic ale_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ale_q <= 1'b0;
      fetch_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      p0_pins <= '0;
      port2_pins <= '0;
      p3_pins <= '0;
      port2_strong <= 1'b0;
      alt_in <= '0;
    end else begin
      ale_q <= ale_d;
      fetch_n_q <= fetch_n_d;
      rd_n_q <= rd_n_d;
      p0_pins <= p0_d;
      port2_pins <= port2_d;
      p3_pins <= p3_d;
      port2_strong <= port2_addr;
      alt_in <= alt_d;
    end
  end

  assign addr_latch_en = ale_q;
  assign program_fetch_strobe_n = fetch_n_q;

  // ----------------------------------------
  // core answer registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      code_byte <= 8'h00;
      code_valid <= 1'b0;
      data_ack <= 1'b0;
      data_rdata <= 8'h00;
    end else begin
      code_valid <= code_cap;
      data_ack <= is_data && mc_end;
      if (code_cap) begin
        code_byte <= p0_in;
      end
      if (data_cap) begin
        data_rdata <= p0_in;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ale_width: assert property ($rose(ale_q) |-> ale_q ##1 ale_q ##1 !ale_q)
    else $error("address latch pulse is not two periods wide");
  a_ale_rate: assert property (
      $rose(ale_q) && !ale_off && is_code && phase == 4'h1 |-> ##6 $rose(ale_q))
    else $error("address latch pulse not at one sixth rate");
  a_ale_skip: assert property (is_data && phase == 4'h7 |-> !ale_q)
    else $error("address latch pulse not dropped in data cycle");
  a_ale_gated: assert property (ale_off && !is_data && phase != 4'h0 |-> !ale_q)
    else $error("address latch pulse runs while disabled");
  a_fetch_twice: assert property (
      is_code && phase == 4'h4 |-> !fetch_n_q ##1 !fetch_n_q ##5 !fetch_n_q)
    else $error("fetch strobe not issued twice");
  a_fetch_skip: assert property (is_data && phase != 4'h0 |-> fetch_n_q)
    else $error("fetch strobe active in data cycle");
  a_port2_wide: assert property (
      is_data && req_q.wide && phase != 4'h0 |-> port2_pins.level == req_q.addr[15:8])
    else $error("port 2 lacks high address on wide move");
  a_port2_narrow: assert property (is_data && !req_q.wide && phase == 4'h5
      |=> port2_pins.level == $past(high_addr_port_latch) && !port2_strong)
    else $error("port 2 lacks latch on narrow move");
  a_port2_strong: assert property (port2_strong |-> port2_pins.oe == 8'hff)
    else $error("address on port 2 not driven hard");
  a_wr_strobe: assert property (
      is_data && req_q.write && phase == 4'h5 && p3_latch[`P3_WR]
      |-> !p3_pins.level[`P3_WR] && p3_pins.level[`P3_RD])
    else $error("write strobe missing in write cycle");
  a_p0_addr: assert property (is_data && phase == 4'h2 |-> p0_pins.oe == 8'hff
      && p0_pins.level == req_q.addr[7:0])
    else $error("port 0 lacks low address");

endmodule // ext_bus_port_pins
`default_nettype wire

// ---- src/ext_bus_defines.svh ----
// timing and field constants for the external bus pin block
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

// ----------------------------------------
// machine cycle layout
// ----------------------------------------
`define MC_LEN 12
`define MC_LAST 4'hb
`define SLOT_LEN 4'h6
`define RESET_HOLD_MC 2

// ----------------------------------------
// offsets within one six-period slot
// ----------------------------------------
`define ALE_FIRST 4'h0
`define ALE_LAST 4'h1
`define ADDR_LAST 4'h2
`define FETCH_FIRST 4'h3
`define FETCH_LAST 4'h5

// ----------------------------------------
// phases within a data cycle
// ----------------------------------------
`define STROBE_FIRST 4'h3
`define STROBE_LAST 4'ha

// ----------------------------------------
// port 3 and port 1 bit positions
// ----------------------------------------
`define P3_RX 0
`define P3_TX 1
`define P3_IRQ0 2
`define P3_IRQ1 3
`define P3_CNT0 4
`define P3_CNT1 5
`define P3_WR 6
`define P3_RD 7
`define P1_T2AUX 1

`endif

// ---- src/ext_bus_pkg.sv ----
// types shared by the external bus pin block
`default_nettype none
package ext_bus_pkg;

  // kind of the current machine cycle
  typedef enum logic [1:0] {
    IDLE_CYC,
    CODE_CYC,
    DATA_CYC
  } bus_cyc_t;

  // data move request from the core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic wide;
  } data_req_t;

  // drive of one 8-bit port
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
    logic [7:0] weak_pu;
  } pin_drive_t;

  // alternate inputs handed to the core
  typedef struct packed {
    logic rx;
    logic irq0;
    logic irq1;
    logic timer_zero_count_in;
    logic timer_one_count_in;
    logic t2_aux;
  } alt_in_t;

endpackage
`default_nettype wire

// ---- src/machine_cycle_timer.sv ----
// oscillator period counter that marks out each machine cycle
`include "ext_bus_defines.svh"
`default_nettype none
module machine_cycle_timer #(
  parameter int unsigned MC_LEN = `MC_LEN
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic [3:0] phase
);

  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  logic [3:0] phase_q;
  logic [3:0] phase_d;

  // wrap after the last period of the cycle
  assign phase_d = (phase_q == 4'(MC_LEN - 1)) ? 4'h0 : phase_q + 4'h1;
  assign phase = phase_q;

  // counter register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_cycle_wrap: assert property (phase_q == 4'(MC_LEN - 1) |=> phase_q == 4'h0)
    else $error("machine cycle did not wrap after twelve periods");

endmodule // machine_cycle_timer
`default_nettype wire

// ---- src/reset_hold_filter.sv ----
// reset pin filter that demands a sustained high level
`include "ext_bus_defines.svh"
`default_nettype none
module reset_hold_filter #(
  parameter int unsigned HOLD = `RESET_HOLD_MC * `MC_LEN
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reset_pin,
  output logic core_reset
);

  // ----------------------------------------
  // high level counter
  // ----------------------------------------
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic core_reset_q;
  logic core_reset_d;
  logic held;

  assign held = (cnt_q == 8'(HOLD - 1));
  // count consecutive high samples, restart on any low
  assign cnt_d = !reset_pin ? 8'h00 : (held ? cnt_q : cnt_q + 8'h01);
  assign core_reset_d = reset_pin && held;
  assign core_reset = core_reset_q;

  // filter registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      core_reset_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      core_reset_q <= core_reset_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_reset_after_hold: assert property (held && reset_pin |=> core_reset_q)
    else $error("reset not taken after two machine cycles high");
  a_reset_short: assert property (!reset_pin |=> !core_reset_q ##1 !core_reset_q)
    else $error("reset taken without a full hold");

endmodule // reset_hold_filter
`default_nettype wire

// ---- sim/ext_mem_model.sv ----
// behavioural external program and data memory with its address latch
`default_nettype none
module ext_mem_model
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire pin_drive_t p0_pins,
  input wire pin_drive_t port2_pins,
  input wire pin_drive_t p3_pins,
  input wire logic addr_latch_en,
  input wire logic program_fetch_strobe_n,
  output logic [7:0] p0_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // latch, strobes and memory
  // ----------------------------------------
  logic [7:0] dmem [256];
  logic [7:0] low_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  wire [15:0] addr = {port2_pins.level, low_q};
  wire [7:0] idx = addr[7:0] ^ addr[15:8];
  wire rd_low = p3_pins.oe[7] & ~p3_pins.level[7];
  wire wr_low = p3_pins.oe[6] & ~p3_pins.level[6];
  wire [7:0] code = addr[7:0] + addr[15:8];
  // released bus shows the inverse of its last value, never a stale copy
  assign p0_in = !program_fetch_strobe_n ? code : (rd_low ? dmem[idx] : ~last_q);
  // low address captured while the latch pulse is high
  always @(posedge sys_clk) begin
    if (addr_latch_en) begin
      low_q <= p0_pins.level;
    end
    if (wr_low) begin
      dmem[idx] <= p0_pins.level;
    end
    last_q <= p0_in;
  end
endmodule // ext_mem_model
`default_nettype wire

// ---- sim/external_bus_port_pins_tb_top.sv ----
// self-checking bench for the external bus pin block
`default_nettype none
module external_bus_port_pins_tb_top
  import ext_bus_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic reset_pin = 1'b0;
  logic code_source_select_n = 1'b0;
  logic fetch_en = 1'b0;
  logic [15:0] code_addr = 16'h12a5;
  logic data_req_valid = 1'b0;
  data_req_t data_req = '0;
  logic ale_off = 1'b0;
  logic [7:0] high_addr_port_latch = 8'h96;
  logic [7:0] p3_latch = 8'hff;
  logic [7:0] p1_in = 8'h00;
  logic [7:0] p3_in = 8'hff;
  logic txd_bit = 1'b1;
  logic [7:0] p0_in;
  logic [7:0] code_byte;
  logic [7:0] data_rdata;
  logic code_valid;
  logic data_ack;
  logic port2_strong;
  logic addr_latch_en;
  logic program_fetch_strobe_n;
  logic core_reset;
  pin_drive_t p0_pins;
  pin_drive_t port2_pins;
  pin_drive_t p3_pins;
  alt_in_t alt_in;
  int n_mismatch = 0;
  int comparisons = 0;
  int ale_hi;
  int strb_lo;
  int stb_lo;
  always #5 sys_clk = ~sys_clk;
  ext_bus_port_pins ext_bus_port_pins_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reset_pin(reset_pin), .code_source_select_n(code_source_select_n),
    .fetch_en(fetch_en), .code_addr(code_addr), .data_req_valid(data_req_valid),
    .data_req(data_req), .ale_off(ale_off), .high_addr_port_latch(high_addr_port_latch),
    .p3_latch(p3_latch), .txd_bit(txd_bit), .p0_in(p0_in), .p1_in(p1_in), .p3_in(p3_in),
    .code_byte(code_byte), .code_valid(code_valid), .data_ack(data_ack),
    .data_rdata(data_rdata), .p0_pins(p0_pins), .port2_pins(port2_pins), .p3_pins(p3_pins),
    .port2_strong(port2_strong), .addr_latch_en(addr_latch_en),
    .program_fetch_strobe_n(program_fetch_strobe_n), .alt_in(alt_in),
    .core_reset(core_reset));
  ext_mem_model ext_mem_model_inst (.sys_clk(sys_clk), .p0_pins(p0_pins),
    .port2_pins(port2_pins), .p3_pins(p3_pins), .addr_latch_en(addr_latch_en),
    .program_fetch_strobe_n(program_fetch_strobe_n), .p0_in(p0_in));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // one edge, then a fixed settle delay used for driving and sampling
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask
  // counts latch-high and strobe-low periods over n cycles
  task automatic span(input int n);
    ale_hi = 0;
    strb_lo = 0;
    repeat (n) begin
      tick();
      ale_hi += int'(addr_latch_en === 1'b1);
      strb_lo += int'(program_fetch_strobe_n === 1'b0);
    end
  endtask
  // one data move; counts taken over the 12 periods of the data cycle
  task automatic data_move(input logic wide, input logic wr, input logic [15:0] a,
      input logic [7:0] wd);
    int al[64];
    int st[64];
    int sb[64];
    int k;
    tick();
    k = 0;
    data_req = '{addr: a, wdata: wd, write: wr, wide: wide};
    data_req_valid = 1'b1;
    while (k < 60 && data_ack !== 1'b1) begin
      tick();
      al[k] = int'(addr_latch_en === 1'b1);
      st[k] = int'(program_fetch_strobe_n === 1'b0);
      sb[k] = int'((p3_pins.oe[wr ? 6 : 7] & ~p3_pins.level[wr ? 6 : 7]) === 1'b1);
      k++;
    end
    data_req_valid = 1'b0;
    ale_hi = 0;
    strb_lo = 0;
    stb_lo = 0;
    if (k < 13 || k >= 60) begin
      n_mismatch++;
      $display("MISMATCH t=%0t data move answer missing", $time);
    end else begin
      for (int i = k - 12; i < k; i++) begin
        ale_hi += al[i];
        strb_lo += st[i];
        stb_lo += sb[i];
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic idle_check();
    span(24);
    chk_count(ale_hi, 8);
    chk_count(strb_lo, 0);
    chk_byte(port2_pins.weak_pu, 8'h96);
    chk_byte(port2_pins.oe, 8'h69);
    chk_byte({7'h00, port2_strong}, 8'h00);
    code_source_select_n = 1'b1;
    fetch_en = 1'b1;
    span(24);
    chk_count(strb_lo, 0);
    code_source_select_n = 1'b0;
    fetch_en = 1'b0;
    span(12);
  endtask
  task automatic fetch_check(input logic [15:0] a);
    int k;
    code_addr = a;
    fetch_en = 1'b1;
    span(13);
    k = 0;
    while (k < 30 && code_valid !== 1'b1) begin
      tick();
      k++;
    end
    chk_count(int'(k < 30), 1);
    chk_byte(code_byte, 8'(a[7:0] + a[15:8]));
    chk_byte(port2_pins.level, a[15:8]);
    chk_byte({7'h00, port2_strong}, 8'h01);
    span(24);
    chk_count(strb_lo, 12);
    chk_count(ale_hi, 8);
    fetch_en = 1'b0;
    span(12);
  endtask
  task automatic data_check();
    data_move(1'b1, 1'b1, 16'h3c01, 8'h5a);
    chk_count(ale_hi, 2);
    chk_count(strb_lo, 0);
    chk_count(stb_lo, 8);
    data_move(1'b1, 1'b1, 16'h96c3, 8'h3e);
    data_move(1'b1, 1'b0, 16'h3c01, 8'h00);
    chk_byte(data_rdata, 8'h5a);
    chk_count(stb_lo, 8);
    data_move(1'b0, 1'b0, 16'h00c3, 8'h00);
    chk_byte(data_rdata, 8'h3e);
    ale_off = 1'b1;
    span(12);
    span(24);
    chk_count(ale_hi, 0);
    data_move(1'b1, 1'b0, 16'h3c01, 8'h00);
    chk_count(ale_hi, 2);
    ale_off = 1'b0;
  endtask
  task automatic alt_check(input logic [7:0] pat);
    logic [7:0] exp;
    exp = {2'b00, pat[0], pat[2], pat[3], pat[4], pat[5], pat[1]};
    p3_in = pat;
    p1_in = pat;
    tick();
    tick();
    chk_byte({2'b00, alt_in}, exp);
  endtask
  task automatic txd_check();
    txd_bit = 1'b0;
    tick();
    tick();
    chk_byte({6'h00, p3_pins.oe[1], p3_pins.level[1]}, 8'h02);
    txd_bit = 1'b1;
    tick();
    tick();
    chk_byte({6'h00, p3_pins.oe[1], p3_pins.weak_pu[1]}, 8'h01);
    // latch zeros drive low, latch ones only pull up
    p3_latch = 8'hbe;
    tick();
    tick();
    chk_byte(p3_pins.oe, 8'h41);
    chk_byte(p3_pins.weak_pu, 8'hbe);
    p3_latch = 8'hff;
    tick();
  endtask
  task automatic reset_check();
    int seen;
    seen = 0;
    reset_pin = 1'b1;
    repeat (23) tick();
    reset_pin = 1'b0;
    repeat (4) begin
      tick();
      seen += int'(core_reset === 1'b1);
    end
    chk_count(seen, 0);
    reset_pin = 1'b1;
    repeat (23) tick();
    chk_byte({7'h00, core_reset}, 8'h00);
    tick();
    chk_byte({7'h00, core_reset}, 8'h01);
    reset_pin = 1'b0;
    repeat (3) tick();
    chk_byte({7'h00, core_reset}, 8'h00);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    idle_check();
    fetch_check(16'h12a5);
    fetch_check(16'h4021);
    data_check();
    alt_check(8'ha5);
    alt_check(8'h5a);
    txd_check();
    reset_check();
    summarize();
  end
  // cuts a hang short well beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
endmodule // external_bus_port_pins_tb_top
`default_nettype wire
